//--- tpd_pkg.sv
// tpd_pkg: register map, field positions and reset values of the
// triangle pwm channel with forced duty.
// assumes: a 32-bit apb bus with byte addresses on the low eight bits.
package tpd_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_CMP_A  = 8'h08;
	localparam logic [7:0] OFS_CMP_B  = 8'h0C;
	localparam logic [7:0] OFS_BUF    = 8'h10;
	localparam logic [7:0] OFS_DT_UP  = 8'h14;
	localparam logic [7:0] OFS_DT_DN  = 8'h18;
	localparam logic [7:0] OFS_FORCE  = 8'h1C;
	localparam logic [7:0] OFS_STAT   = 8'h20;
	localparam logic [7:0] OFS_CNT    = 8'h24;

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	localparam int CTL_RUN    = 0;
	localparam int CTL_AUTO   = 1;
	localparam int CTL_BUFEN  = 2;
	localparam int CTL_ACTA   = 3;
	localparam int CTL_ACTB   = 5;
	localparam int CTL_INITA  = 7;
	localparam int CTL_INITB  = 8;

	// ----------------------------------------------------------------
	// forced duty fields
	// ----------------------------------------------------------------
	localparam int FRC_FDA    = 0;
	localparam int FRC_FDB    = 2;
	localparam int FRC_FSA    = 4;
	localparam int FRC_FSB    = 5;
	localparam int FRC_RELA   = 6;
	localparam int FRC_RELB   = 7;

	// ----------------------------------------------------------------
	// status fields
	// ----------------------------------------------------------------
	localparam int STA_PROT   = 0;
	localparam int STA_DOWN   = 1;
	localparam int STA_PINA   = 2;
	localparam int STA_PINB   = 3;

	// ----------------------------------------------------------------
	// cycle-end actions and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]  ACT_KEEP   = 2'h0;
	localparam logic [1:0]  ACT_LOW    = 2'h1;
	localparam logic [1:0]  ACT_HIGH   = 2'h2;
	localparam logic [1:0]  ACT_TOGGLE = 2'h3;
	localparam logic [31:0] RST_PERIOD = 32'h0000_0064;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [31:0] CNT_ONE    = 32'h0000_0001;

endpackage : tpd_pkg

//--- tpd_props.sv
// tpd_props: port-level timing checks of the triangle pwm channel.
// assumes: bound to tpd_top, one clock, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tpd_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pwm_out_positive,
	input wire logic pwm_out_negative,
	input wire logic underflow_irq,
	input wire logic cmp_a_irq,
	input wire logic cmp_b_irq,
	input wire logic output_protection
);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic wr_done;
	assign wr_done = psel & penable & pready & pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_rdy_only; pready |-> psel && penable; endproperty
	a_rdy_only: assert property (p_rdy_only) else $error("ready outside access");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_uf; underflow_irq |=> !underflow_irq; endproperty
	a_uf: assert property (p_uf) else $error("underflow pulse too long");
	property p_ca; cmp_a_irq |=> !cmp_a_irq; endproperty
	a_ca: assert property (p_ca) else $error("compare a pulse too long");
	property p_cb; cmp_b_irq |=> !cmp_b_irq; endproperty
	a_cb: assert property (p_cb) else $error("compare b pulse too long");
	// pins must be low once protection has stood a full cycle
	property p_prot; output_protection && $past(output_protection) |->
		!pwm_out_positive && !pwm_out_negative; endproperty
	a_prot: assert property (p_prot) else $error("pins driven under protection");
	property p_pina; $changed(pwm_out_positive) |-> cmp_a_irq || underflow_irq ||
		$past(underflow_irq) || output_protection || $past(wr_done); endproperty
	a_pina: assert property (p_pina) else $error("pin a moved without cause");
	property p_pinb; $changed(pwm_out_negative) |-> cmp_b_irq || underflow_irq ||
		$past(underflow_irq) || output_protection || $past(wr_done); endproperty
	a_pinb: assert property (p_pinb) else $error("pin b moved without cause");
	c_uf: cover property (underflow_irq);
	c_prot: cover property (output_protection);
	c_err: cover property (pslverr);
endmodule : tpd_props
`default_nettype wire

//--- tpd_stage.sv
// tpd_stage: power stage model, counts cycles each pin spends high.
// assumes: sampled mid-cycle so counts never race the pin update.
`timescale 1ns/100ps
`default_nettype none
module tpd_stage (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_pos,
	input  wire logic pin_neg,
	output var  int   pos_high,
	output var  int   neg_high
);
	// ----------------------------------------------------------------
	// high-time counters
	// ----------------------------------------------------------------
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_high <= 0;
			neg_high <= 0;
		end else begin
			pos_high <= pos_high + int'(pin_pos === 1'b1);
			neg_high <= neg_high + int'(pin_neg === 1'b1);
		end
	end
endmodule : tpd_stage
`default_nettype wire

//--- tpd_top.sv
// tpd_top: one triangle-wave pwm channel, apb register slave,
// automatic dead time, forced 0%/100% duty and output protection.
// assumes: apb master on pclk, counter steps once per pclk.
// Overview of operation
// - with auto dead time, negative compare is derived from positive value
// - zero or above-period positive compare while counting trips protection
// - without auto dead time, zero or period compare matches once per cycle
// - compare above period never matches
// - 100% duty needs forced field 11b on either pin; 10b forces the pin low
// - zero compares still give one-clock pulse after each underflow
// - compare match beats underflow action and toggles the pin
// - matching, compare requests and buffer transfer continue while forced
// - forced pin level decides level after release with action fields
// - cycle-end action 00b keeps the pin level
// - release bit 1 applies cycle-end action to masked match value
// - start forcing bit with 10b makes pin a low at count start
// - forced field written while counting acts from the next underflow
// - pin b field 11b holds high, 10b holds low per forced cycle
// - positive compare is single buffered from the duty buffer register
// - counter starts at zero and counts up toward the period
// - each pin drives a programmable level at count start
// - unforced pins toggle on their compare match
// - one underflow request per carrier cycle at the trough
// - field 00b releases forcing from the next underflow
// - pin a duty splits half in up phase, half in down phase
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module tpd_top
	import tpd_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        pwm_out_positive,
	output var  logic        pwm_out_negative,
	output var  logic        underflow_irq,
	output var  logic        cmp_a_irq,
	output var  logic        cmp_b_irq,
	output var  logic        output_protection
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        run;
		logic        auto_dt;
		logic        buf_en;
		logic [1:0]  act_a;
		logic [1:0]  act_b;
		logic        init_a;
		logic        init_b;
		logic [31:0] period;
		logic [31:0] cmp_a;
		logic [31:0] cmp_b;
		logic [31:0] buf_v;
		logic [31:0] dtu;
		logic [31:0] dtd;
		logic [31:0] cnt;
		logic        down;
		logic [1:0]  fd_a;
		logic [1:0]  fd_b;
		logic        fs_a;
		logic        fs_b;
		logic        rel_a;
		logic        rel_b;
		logic        frc_a;
		logic        frc_b;
		logic        flv_a;
		logic        flv_b;
		logic        sh_a;
		logic        sh_b;
		logic        pin_a;
		logic        pin_b;
		logic        back_a;
		logic        back_b;
		logic        prot;
		logic        uf;
		logic        ma;
		logic        mb;
		logic        out_a;
		logic        out_b;
		logic        ready;
		logic        slverr;
		logic [31:0] rdata;
	} tpd_st_t;

	tpd_st_t st_r;
	tpd_st_t st_nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic tpd_cycle_end(input logic [1:0] act, input logic lvl);
		case (act)
			ACT_KEEP:   tpd_cycle_end = lvl;
			ACT_LOW:    tpd_cycle_end = 1'b0;
			ACT_HIGH:   tpd_cycle_end = 1'b1;
			default:    tpd_cycle_end = ~lvl;
		endcase
	endfunction : tpd_cycle_end

	// returns {shadow, pin, back}; shadow is the compare-match level that
	// keeps running under forcing so it can be handed back on release
	function automatic logic [2:0] tpd_pin_step(
		input logic       match,
		input logic       uf,
		input logic       zero_cmp,
		input logic       back,
		input logic       was_frc,
		input logic       frc,
		input logic       flv,
		input logic       rel,
		input logic [1:0] act,
		input logic       sh,
		input logic       pin
	);
		logic s;
		logic p;
		logic b;
		s = sh;
		p = pin;
		b = 1'b0;
		if (back) begin
			s = ~sh;
		end else if (match) begin
			s = ~sh;
			b = uf & zero_cmp;
		end else if (uf) begin
			s = tpd_cycle_end(act, sh);
		end
		if (frc) begin
			p = flv;
		end else if (uf && was_frc) begin
			if (rel) begin
				p = s;
			end else begin
				p = tpd_cycle_end(act, pin);
				s = p;
			end
		end else begin
			p = s;
		end
		tpd_pin_step = {s, p, b};
	endfunction : tpd_pin_step

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic        acc;
	logic        wr;
	logic        start;
	logic        uf;
	logic        ma;
	logic        mb;
	logic [31:0] cmp_b_eff;
	logic [31:0] rd;
	logic        hit;
	logic        prot_set;
	logic [2:0]  step_a;
	logic [2:0]  step_b;

	always_comb begin
		st_nxt = st_r;
		acc = psel & penable & st_r.ready;
		wr = acc & pwrite;
		start = 1'b0;
		prot_set = 1'b0;

		// derived compare, ahead of the read mux that returns it
		// both negative-phase edges sit below the positive compare, so the
		// gap opens on both sides of the positive pulse
		cmp_b_eff = st_r.cmp_b;
		if (st_r.auto_dt) begin
			if (st_r.down) begin
				cmp_b_eff = st_r.cmp_a - st_r.dtd;
			end else begin
				cmp_b_eff = st_r.cmp_a - st_r.dtu;
			end
		end

		// apb: ready is raised in the setup cycle, so every access is zero-wait
		st_nxt.ready = psel & ~penable;
		hit = 1'b1;
		rd = RST_WORD;
		case (paddr)
			OFS_CTRL: begin
				rd[CTL_RUN] = st_r.run;
				rd[CTL_AUTO] = st_r.auto_dt;
				rd[CTL_BUFEN] = st_r.buf_en;
				rd[CTL_ACTA +: 2] = st_r.act_a;
				rd[CTL_ACTB +: 2] = st_r.act_b;
				rd[CTL_INITA] = st_r.init_a;
				rd[CTL_INITB] = st_r.init_b;
			end
			OFS_PERIOD: rd = st_r.period;
			OFS_CMP_A:  rd = st_r.cmp_a;
			OFS_CMP_B:  rd = cmp_b_eff;
			OFS_BUF:    rd = st_r.buf_v;
			OFS_DT_UP:  rd = st_r.dtu;
			OFS_DT_DN:  rd = st_r.dtd;
			OFS_FORCE: begin
				rd[FRC_FDA +: 2] = st_r.fd_a;
				rd[FRC_FDB +: 2] = st_r.fd_b;
				rd[FRC_FSA] = st_r.fs_a;
				rd[FRC_FSB] = st_r.fs_b;
				rd[FRC_RELA] = st_r.rel_a;
				rd[FRC_RELB] = st_r.rel_b;
			end
			OFS_STAT: begin
				rd[STA_PROT] = st_r.prot;
				rd[STA_DOWN] = st_r.down;
				rd[STA_PINA] = st_r.out_a;
				rd[STA_PINB] = st_r.out_b;
			end
			OFS_CNT:    rd = st_r.cnt;
			default:    hit = 1'b0;
		endcase
		st_nxt.rdata = (psel & ~penable & ~pwrite) ? rd : st_r.rdata;
		st_nxt.slverr = psel & ~penable & ~hit;

		// carrier counter and events
		// trough only on the way down, so the start value is no underflow
		uf = st_r.run & st_r.down & (st_r.cnt == RST_WORD);
		// equality only: a compare beyond the period is never reached
		ma = st_r.run & (st_r.cnt == st_r.cmp_a);
		mb = st_r.run & (st_r.cnt == cmp_b_eff);
		st_nxt.uf = uf;
		st_nxt.ma = ma;
		st_nxt.mb = mb;

		if (st_r.run) begin
			if (uf) begin
				st_nxt.down = 1'b0;
				st_nxt.cnt = st_r.cnt + CNT_ONE;
			end else if (!st_r.down && st_r.cnt >= st_r.period) begin
				st_nxt.down = 1'b1;
				st_nxt.cnt = st_r.cnt - CNT_ONE;
			end else if (st_r.down) begin
				st_nxt.cnt = st_r.cnt - CNT_ONE;
			end else begin
				st_nxt.cnt = st_r.cnt + CNT_ONE;
			end
		end

		// buffer transfer at the trough, also while forced
		if (uf && st_r.buf_en) begin
			st_nxt.cmp_a = st_r.buf_v;
			if (st_r.buf_v == RST_WORD || st_r.buf_v > st_r.period) begin
				st_nxt.prot = 1'b1;
				prot_set = 1'b1;
			end
		end

		// forced duty latched at each underflow
		if (uf) begin
			st_nxt.frc_a = st_r.fd_a[1];
			st_nxt.flv_a = st_r.fd_a[0];
			st_nxt.frc_b = st_r.fd_b[1];
			st_nxt.flv_b = st_r.fd_b[0];
		end

		step_a = tpd_pin_step(ma, uf, st_r.cmp_a == RST_WORD, st_r.back_a, st_r.frc_a,
			st_nxt.frc_a, st_nxt.flv_a, st_r.rel_a, st_r.act_a, st_r.sh_a, st_r.pin_a);
		step_b = tpd_pin_step(mb, uf, cmp_b_eff == RST_WORD, st_r.back_b, st_r.frc_b,
			st_nxt.frc_b, st_nxt.flv_b, st_r.rel_b, st_r.act_b, st_r.sh_b, st_r.pin_b);
		if (st_r.run) begin
			{st_nxt.sh_a, st_nxt.pin_a, st_nxt.back_a} = step_a;
			{st_nxt.sh_b, st_nxt.pin_b, st_nxt.back_b} = step_b;
		end

		// register writes
		if (wr) begin
			case (paddr)
				OFS_CTRL: begin
					start = pwdata[CTL_RUN] & ~st_r.run;
					st_nxt.run = pwdata[CTL_RUN];
					st_nxt.auto_dt = pwdata[CTL_AUTO];
					st_nxt.buf_en = pwdata[CTL_BUFEN];
					st_nxt.act_a = pwdata[CTL_ACTA +: 2];
					st_nxt.act_b = pwdata[CTL_ACTB +: 2];
					st_nxt.init_a = pwdata[CTL_INITA];
					st_nxt.init_b = pwdata[CTL_INITB];
				end
				OFS_PERIOD: st_nxt.period = pwdata;
				OFS_CMP_A: begin
					st_nxt.cmp_a = pwdata;
					if (st_r.run && (pwdata == RST_WORD || pwdata > st_r.period)) begin
						st_nxt.prot = 1'b1;
						prot_set = 1'b1;
					end
				end
				OFS_CMP_B:  st_nxt.cmp_b = pwdata;
				OFS_BUF:    st_nxt.buf_v = pwdata;
				OFS_DT_UP:  st_nxt.dtu = pwdata;
				OFS_DT_DN:  st_nxt.dtd = pwdata;
				OFS_FORCE: begin
					st_nxt.fd_a = pwdata[FRC_FDA +: 2];
					st_nxt.fd_b = pwdata[FRC_FDB +: 2];
					st_nxt.fs_a = pwdata[FRC_FSA];
					st_nxt.fs_b = pwdata[FRC_FSB];
					st_nxt.rel_a = pwdata[FRC_RELA];
					st_nxt.rel_b = pwdata[FRC_RELB];
				end
				// status and counter are read-only, so their writes drop here
				default: begin
				end
			endcase
		end

		// count start: counter from zero, pins at their start levels
		// forcing at start skips the wait for the first underflow
		if (start) begin
			st_nxt.cnt = RST_WORD;
			st_nxt.down = 1'b0;
			st_nxt.sh_a = st_r.init_a;
			st_nxt.sh_b = st_r.init_b;
			st_nxt.back_a = 1'b0;
			st_nxt.back_b = 1'b0;
			st_nxt.frc_a = st_r.fs_a & st_r.fd_a[1];
			st_nxt.flv_a = st_r.fd_a[0];
			st_nxt.frc_b = st_r.fs_b & st_r.fd_b[1];
			st_nxt.flv_b = st_r.fd_b[0];
			st_nxt.pin_a = (st_r.fs_a & st_r.fd_a[1]) ? st_r.fd_a[0] : st_r.init_a;
			st_nxt.pin_b = (st_r.fs_b & st_r.fd_b[1]) ? st_r.fd_b[0] : st_r.init_b;
		end
		// protection latches until the counter is stopped; a trip in the
		// stopping cycle wins and clears one cycle later
		if (!st_nxt.run && !prot_set) begin
			st_nxt.prot = 1'b0;
		end

		// protection gates last, over forcing and start levels
		st_nxt.out_a = st_nxt.pin_a & ~st_nxt.prot;
		st_nxt.out_b = st_nxt.pin_b & ~st_nxt.prot;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// period resets to a usable carrier so a bare start runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.period <= RST_PERIOD;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata            = st_r.rdata;
	assign pready            = st_r.ready;
	assign pslverr           = st_r.slverr;
	assign pwm_out_positive  = st_r.out_a;
	assign pwm_out_negative  = st_r.out_b;
	assign underflow_irq     = st_r.uf;
	assign cmp_a_irq         = st_r.ma;
	assign cmp_b_irq         = st_r.mb;
	assign output_protection = st_r.prot;

endmodule : tpd_top

`default_nettype wire

//--- triangle_pwm_duty_forcing_test.sv
// triangle_pwm_duty_forcing_test: scenario bench over apb.
// assumes: tpd_top, tpd_props and tpd_stage compiled before.
`timescale 1ns/100ps
`default_nettype none
module triangle_pwm_duty_forcing_test;
	import tpd_pkg::*;
	// ----------------------------------------------------------------
	// harness
	// ----------------------------------------------------------------
	localparam int P = 8;
	localparam int C = 3;
	localparam int DU = 1;
	localparam int DD = 2;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        pa, pb, uf, ca_irq, cb_irq, prot;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	int          a_hi, b_hi, bad_count, num_checks, n, a, b, c, d;
	tpd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_out_positive(pa), .pwm_out_negative(pb),
		.underflow_irq(uf), .cmp_a_irq(ca_irq), .cmp_b_irq(cb_irq), .output_protection(prot));
	tpd_stage stage (.pclk(pclk), .presetn(presetn), .pin_pos(pa), .pin_neg(pb),
		.pos_high(a_hi), .neg_high(b_hi));
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		#50us;
		bad_count++;
		results;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int t;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		t = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
		if (t >= 50) chk(pready, 1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : xfer
	task wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1, ad, d, q, e);
	endtask : wr
	// one carrier from underflow to underflow: length, pin highs, a and b matches
	task carrier;
		int t, a0, b0;
		t = 0;
		do begin @(posedge pclk); #1; t++; end while (uf !== 1'b1 && t < 99);
		a0 = a_hi;
		b0 = b_hi;
		n = 0;
		c = 0;
		d = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
			if (ca_irq === 1'b1) c++;
			if (cb_irq === 1'b1) d++;
		end while (uf !== 1'b1 && n < 99);
		a = a_hi - a0;
		b = b_hi - b0;
	endtask : carrier
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		logic [31:0] q;
		logic        e;
		xfer(0, OFS_PERIOD, 0, q, e);
		chk(q, RST_PERIOD);
		xfer(0, 8'h40, 0, q, e);
		chk(e, 1);
		chk(q, RST_WORD);
		wr(OFS_CNT, 32'h0000_0005);
		xfer(0, OFS_CNT, 0, q, e);
		chk(q, RST_WORD);
	endtask : t_regs
	task t_start;
		wr(OFS_PERIOD, P);
		wr(OFS_DT_UP, DU);
		wr(OFS_DT_DN, DD);
		wr(OFS_CMP_A, C);
		wr(OFS_FORCE, 32'h0000_003E);
		wr(OFS_CTRL, 32'h0000_0003);
		@(posedge pclk);
		#1;
		chk(pa, 0);
		chk(pb, 1);
		carrier;
		chk(n, 2 * P);
		chk(a, 0);
		chk(b, 2 * P);
		chk(c, 2);
		chk(d, 2);
	endtask : t_start
	task t_flip;
		wr(OFS_FORCE, 32'h0000_000B);
		carrier;
		chk(a, 2 * P);
		chk(b, 0);
	endtask : t_flip
	task t_release;
		wr(OFS_FORCE, 32'h0000_0000);
		carrier;
		chk(n, 2 * P);
		chk(a == 2 * C || a == 2 * (P - C), 1);
		chk(b == 2 * (P - C) + DU + DD || b == 2 * C - DU - DD, 1);
	endtask : t_release
	task t_buf;
		logic [31:0] q;
		logic        e;
		wr(OFS_CTRL, 32'h0000_0007);
		wr(OFS_BUF, 32'h0000_0005);
		carrier;
		xfer(0, OFS_CMP_A, 0, q, e);
		chk(q, 32'h0000_0005);
		xfer(0, OFS_CMP_B, 0, q, e);
		chk(q, 32'h0000_0005 - DU);
		repeat (6) @(posedge pclk);
		xfer(0, OFS_CMP_B, 0, q, e);
		chk(q, 32'h0000_0005 - DD);
	endtask : t_buf
	task t_prot;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CMP_A, i ? P + 1 : 0);
			@(posedge pclk);
			#1;
			chk(prot, 1);
			chk({pa, pb}, 0);
			wr(OFS_CTRL, 32'h0000_0000);
			@(posedge pclk);
			#1;
			chk(prot, 0);
			wr(OFS_CMP_A, C);
			wr(OFS_BUF, C);
			wr(OFS_CTRL, 32'h0000_0003);
		end
	endtask : t_prot
	// zero compares without dead time: one match and a one-clock dip per carrier
	task t_zero;
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_CMP_A, RST_WORD);
		wr(OFS_CMP_B, RST_WORD);
		wr(OFS_CTRL, 32'h0000_0001);
		carrier;
		chk(c, 1);
		chk(d, 1);
		chk(a, 2 * P - 1);
		chk(b, 2 * P - 1);
	endtask : t_zero
	// release bit set: the masked match level comes back after forcing
	task t_rel1;
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_CMP_A, C);
		wr(OFS_FORCE, 32'h0000_00C3);
		wr(OFS_CTRL, 32'h0000_0003);
		carrier;
		chk(a, 2 * P);
		wr(OFS_FORCE, 32'h0000_00C0);
		carrier;
		chk(a, 2 * (P - C));
	endtask : t_rel1
	task results;
		if (bad_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		bad_count = 0;
		num_checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_start;
		t_flip;
		t_release;
		t_buf;
		t_prot;
		t_zero;
		t_rel1;
		results;
	end
endmodule : triangle_pwm_duty_forcing_test
bind tpd_top tpd_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.pwm_out_positive(pwm_out_positive), .pwm_out_negative(pwm_out_negative),
	.underflow_irq(underflow_irq), .cmp_a_irq(cmp_a_irq), .cmp_b_irq(cmp_b_irq),
	.output_protection(output_protection));
`default_nettype wire
